// File: autoneg_next_page_regs.sv
// management registers of the auto-negotiation engine: expansion, next page transmit and receive, extended status
// assumes one-cycle read and write strobes from the management serial decoder
// assumes the auto-negotiation engine pulses page_valid and page_sent for one cycle each
//
// Overview of operation
// - expansion bit 2 reads one, bits 15:3 and 0 read zero
// - page-received flag sets on a new page, clears on read, resets zero
// - transmit bit 15 is more-pages, writable, reset zero; bit 14 reads zero
// - transmit bit 12 is writable acknowledge-2, reset zero
// - transmit bit 11 is read-only toggle, flips per next page sent
// - transmit code bits 10:0 reset to null message, bit 13 resets one
// - receive register shows partner page fields read-only, reset zero
// - receive bit 14 reports a base or next page was received
// - receive bit 11 shows the partner toggle bit
// - extended status bit 15 always reads one
// - extended status bit 14 always reads zero
// - extended status bits 13 to 0 always read zero
// - unmapped addresses are read-only and read zero
`timescale 1ns/100ps
`default_nettype none
`include "autoneg_np_defs.svh"
module autoneg_next_page_regs (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [4:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic page_valid,
   input wire logic page_is_base,
   input wire autoneg_np_pkg::page_s page_in,
   input wire logic page_sent,
   output autoneg_np_pkg::page_s tx_page
);
   // ************************************************************
   // address decode
   // ************************************************************
   // a read in the same cycle as a write is dropped, so it never clears the flag unseen
   logic write_taken;
   logic read_taken;
   logic sel_expansion;
   logic sel_tx_page;
   logic sel_rx_page;
   logic sel_ext_status;
   logic sel_unmapped;

   assign write_taken = reg_write;
   assign read_taken = reg_read && !reg_write;
   assign sel_expansion = (reg_addr == `ADDR_AUTONEG_EXPANSION);
   assign sel_tx_page = (reg_addr == `ADDR_NEXT_PAGE_TRANSMIT);
   assign sel_rx_page = (reg_addr == `ADDR_NEXT_PAGE_RECEIVE);
   assign sel_ext_status = (reg_addr == `ADDR_EXTENDED_STATUS);
   assign sel_unmapped = !(sel_expansion || sel_tx_page || sel_rx_page || sel_ext_status);

   // ************************************************************
   // received page capture
   // ************************************************************
   logic flag_read;
   logic page_received;
   logic page_acknowledged;
   autoneg_np_pkg::page_s page_held;

   assign flag_read = read_taken && sel_expansion;

   page_capture capture (
      .ref_clk(ref_clk),
      .reset(reset),
      .page_valid(page_valid),
      .page_in(page_in),
      .page_is_base(page_is_base),
      .flag_read(flag_read),
      .page_received(page_received),
      .page_acknowledged(page_acknowledged),
      .page_held(page_held)
   );

   // ************************************************************
   // transmit page register
   // ************************************************************
   // the written word mapped onto page fields; bit 14 has no field and is dropped
   autoneg_np_pkg::page_s wdata_page;
   autoneg_np_pkg::page_s next_tx_page;
   logic tx_write;

   assign tx_write = write_taken && sel_tx_page;

   always_comb begin
      wdata_page.more_pages = reg_wdata[`NPT_MORE_PAGES_BIT];
      wdata_page.message_page = reg_wdata[`NPT_MESSAGE_PAGE_BIT];
      wdata_page.ack2 = reg_wdata[`NPT_ACK2_BIT];
      wdata_page.toggle = reg_wdata[`NPT_TOGGLE_BIT];
      wdata_page.code = reg_wdata[`NPT_CODE_MSB:0];
   end

   always_comb begin
      next_tx_page = tx_page;
      // software owns every field but the toggle, which follows the page actually sent
      if (tx_write) begin
         next_tx_page = wdata_page;
         next_tx_page.toggle = tx_page.toggle;
      end
      if (page_sent) begin
         next_tx_page.toggle = ~tx_page.toggle;
      end
   end

   // reset loads the null message page, ready to send as it stands
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_page.more_pages <= 1'b0;
         tx_page.message_page <= `NPT_MESSAGE_PAGE_RESET;
         tx_page.ack2 <= 1'b0;
         tx_page.toggle <= 1'b0;
         tx_page.code <= `NPT_CODE_RESET;
      end else begin
         tx_page <= next_tx_page;
      end
   end

   // ************************************************************
   // register read words
   // ************************************************************
   // each word is built field by field so that reserved bits stay zero
   logic [15:0] expansion_word;
   logic [15:0] tx_page_word;
   logic [15:0] rx_page_word;
   logic [15:0] ext_status_word;

   always_comb begin
      expansion_word = 16'h0000;
      expansion_word[`EXP_NEXT_PAGE_ABLE_BIT] = 1'b1;
      expansion_word[`EXP_PAGE_RECEIVED_BIT] = page_received;
   end

   // bit 14 of the transmit word has no storage and reads zero
   always_comb begin
      tx_page_word = 16'h0000;
      tx_page_word[`NPT_MORE_PAGES_BIT] = tx_page.more_pages;
      tx_page_word[`NPT_MESSAGE_PAGE_BIT] = tx_page.message_page;
      tx_page_word[`NPT_ACK2_BIT] = tx_page.ack2;
      tx_page_word[`NPT_TOGGLE_BIT] = tx_page.toggle;
      tx_page_word[`NPT_CODE_MSB:0] = tx_page.code;
   end

   // the receive fields and the flag come from one capture, so a read never sees half a page
   always_comb begin
      rx_page_word = 16'h0000;
      rx_page_word[`NPT_MORE_PAGES_BIT] = page_held.more_pages;
      rx_page_word[`NPR_ACK_BIT] = page_acknowledged;
      rx_page_word[`NPT_MESSAGE_PAGE_BIT] = page_held.message_page;
      rx_page_word[`NPT_ACK2_BIT] = page_held.ack2;
      rx_page_word[`NPT_TOGGLE_BIT] = page_held.toggle;
      rx_page_word[`NPT_CODE_MSB:0] = page_held.code;
   end

   // only full-duplex serial gigabit is offered; the other abilities read zero
   always_comb begin
      ext_status_word = `EXT_STATUS_VALUE;
      ext_status_word[`EXT_FULL_DUPLEX_X_BIT] = 1'b1;
      ext_status_word[`EXT_HALF_DUPLEX_X_BIT] = 1'b0;
   end

   // ************************************************************
   // read select
   // ************************************************************
   // and-or select per bit: an unmapped address selects no word and reads zero
   logic [15:0] read_word;

   for (genvar b = 0; b < 16; b = b + 1) begin : g_read_bit
      assign read_word[b] = (sel_expansion && expansion_word[b]) || (sel_tx_page && tx_page_word[b])
         || (sel_rx_page && rx_page_word[b]) || (sel_ext_status && ext_status_word[b]);
   end

   // ************************************************************
   // access decode
   // ************************************************************
   autoneg_np_pkg::access_e access;

   always_comb begin
      access = autoneg_np_pkg::idle_st;
      if (write_taken) begin
         access = autoneg_np_pkg::write_st;
      end else if (read_taken) begin
         access = autoneg_np_pkg::read_st;
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   logic [15:0] next_reg_rdata;
   logic next_reg_rvalid;

   always_comb begin
      // read data stands until the next read, so idle and write cycles keep it
      next_reg_rdata = reg_rdata;
      next_reg_rvalid = 1'b0;
      case (access)
         autoneg_np_pkg::read_st: begin
            next_reg_rvalid = 1'b1;
            if (sel_unmapped) begin
               next_reg_rdata = 16'h0000;
            end else begin
               next_reg_rdata = read_word;
            end
         end
         autoneg_np_pkg::write_st: begin
            // writes answer nothing on the read port
            next_reg_rvalid = 1'b0;
         end
         default: begin
            next_reg_rvalid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end
endmodule
`default_nettype wire

// File: autoneg_np_defs.svh
// constants for the auto-negotiation next page register set
// assumes a 5-bit management register address and 16-bit register data
`ifndef AUTONEG_NP_DEFS_SVH
`define AUTONEG_NP_DEFS_SVH
`define ADDR_AUTONEG_EXPANSION 5'h06
`define ADDR_NEXT_PAGE_TRANSMIT 5'h07
`define ADDR_NEXT_PAGE_RECEIVE 5'h08
`define ADDR_EXTENDED_STATUS 5'h0f
`define EXP_NEXT_PAGE_ABLE_BIT 2
`define EXP_PAGE_RECEIVED_BIT 1
`define NPT_MORE_PAGES_BIT 15
`define NPT_MESSAGE_PAGE_BIT 13
`define NPT_ACK2_BIT 12
`define NPT_TOGGLE_BIT 11
`define NPT_CODE_MSB 10
`define NPR_ACK_BIT 14
`define EXT_FULL_DUPLEX_X_BIT 15
`define EXT_HALF_DUPLEX_X_BIT 14
`define EXT_STATUS_VALUE 16'h8000
`define NPT_CODE_RESET 11'h001
`define NPT_MESSAGE_PAGE_RESET 1'h1
`endif

// File: autoneg_np_pkg.sv
// types shared by the next page register files
// assumes the defs header supplies the bit positions
package autoneg_np_pkg;
   typedef struct packed {
      logic more_pages;
      logic message_page;
      logic ack2;
      logic toggle;
      logic [10:0] code;
   } page_s;
   typedef enum logic [1:0] {
      idle_st = 2'b00,
      write_st = 2'b01,
      read_st = 2'b11
   } access_e;
endpackage

// File: page_capture.sv
// captures a received next page and raises the page-received flag on any page
// assumes page_valid is a one-cycle pulse from the auto-negotiation engine
`timescale 1ns/100ps
`default_nettype none
module page_capture (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic page_valid,
   input wire autoneg_np_pkg::page_s page_in,
   input wire logic page_is_base,
   input wire logic flag_read,
   output logic page_received,
   output logic page_acknowledged,
   output autoneg_np_pkg::page_s page_held
);
   logic next_page_received;
   logic next_page_acknowledged;
   autoneg_np_pkg::page_s next_page_held;

   always_comb begin
      next_page_received = page_received;
      next_page_acknowledged = page_acknowledged;
      next_page_held = page_held;
      // the clear by a read loses to a page landing in the same cycle
      if (flag_read) begin
         next_page_received = 1'b0;
      end
      if (page_valid) begin
         next_page_received = 1'b1;
         next_page_acknowledged = 1'b1;
         if (!page_is_base) begin
            next_page_held = page_in;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         page_received <= 1'b0;
         page_acknowledged <= 1'b0;
         page_held <= '0;
      end else begin
         page_received <= next_page_received;
         page_acknowledged <= next_page_acknowledged;
         page_held <= next_page_held;
      end
   end
endmodule
`default_nettype wire

// File: autoneg_next_page_regs_properties.sv
// port assertions for the next page register set
// assumes a bind onto autoneg_next_page_regs
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module autoneg_np_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [4:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic page_valid,
   input wire logic page_is_base,
   input wire autoneg_np_pkg::page_s page_in,
   input wire logic page_sent,
   input wire autoneg_np_pkg::page_s tx_page
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire logic rd = reg_read && !reg_write;
   sequence rd_at(a);
      rd && reg_addr == a;
   endsequence
   sequence rd_exp;
      rd_at(5'h06) && !page_valid;
   endsequence
   read_answer_a: assert property (rd |=> reg_rvalid) else $error("read unanswered");
   ext_status_a: assert property (rd_at(5'h0f) |=> reg_rdata == 16'h8000) else $error("ext status");
   unmapped_zero_a: assert property (rd && !(reg_addr inside {5'h06, 5'h07, 5'h08, 5'h0f}) |=> reg_rdata == 16'h0000)
      else $error("unmapped read");
   exp_const_a: assert property (rd_at(5'h06) |=> reg_rdata[15:2] == 14'h0001 && !reg_rdata[0])
      else $error("expansion constants");
   flag_clear_a: assert property (rd_exp ##1 !page_valid ##1 rd_exp |=> !reg_rdata[1]) else $error("flag kept");
   flag_set_a: assert property (page_valid ##1 rd_at(5'h06) |=> reg_rdata[1]) else $error("flag not set");
   rx_load_a: assert property (page_valid && !page_is_base ##1 rd_at(5'h08)
      |=> reg_rdata == {$past(page_in[14], 2), 1'b1, $past(page_in[13:0], 2)}) else $error("receive page");
   tx_write_a: assert property (reg_write && reg_addr == 5'h07 && !page_sent |=> tx_page ==
      {$past(reg_wdata[15]), $past(reg_wdata[13:12]), $past(tx_page[11]), $past(reg_wdata[10:0])}) else $error("tx write");
   toggle_flip_a: assert property (page_sent |=> tx_page[11] != $past(tx_page[11])) else $error("toggle");
   tx_read_a: assert property (rd_at(5'h07) |=> reg_rdata == {$past(tx_page[14]), 1'b0, $past(tx_page[13:0])})
      else $error("tx read");
endmodule
bind autoneg_next_page_regs autoneg_np_checker i_autoneg_np_checker (.ref_clk(ref_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .page_valid(page_valid), .page_is_base(page_is_base), .page_in(page_in),
   .page_sent(page_sent), .tx_page(tx_page));
`default_nettype wire

// File: an_engine_model.sv
// auto-negotiation engine stand-in: received pages and sent strobes
// assumes its tasks are called just after a falling edge
`timescale 1ns/100ps
`default_nettype none
// ****
// page source
// ****
module an_engine_model (
   input wire logic ref_clk,
   output logic page_valid,
   output logic page_is_base,
   output autoneg_np_pkg::page_s page_in,
   output logic page_sent
);
   logic tgl = 1'b0;
   initial begin
      {page_valid, page_is_base, page_sent} = 3'h0;
      page_in = '0;
   end
   task rx(input logic [14:0] f, input logic base);
      page_in = {f[14:12], tgl, f[10:0]};
      page_is_base = base;
      page_valid = 1'b1;
      if (!base) tgl = ~tgl;
      @(negedge ref_clk);
      page_valid = 1'b0;
      page_in = ~page_in; // idle fields are junk, never the last page
   endtask
   task sent();
      page_sent = 1'b1;
      @(negedge ref_clk);
      page_sent = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: autoneg_next_page_regs_tb_top.sv
// self-checking bench for the next page register set
// assumes the design, checker and engine model compile first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
// ****
// bench top
// ****
module autoneg_next_page_regs_tb_top;
   logic ref_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic reg_rvalid, page_valid, page_is_base, page_sent;
   autoneg_np_pkg::page_s page_in, tx_page;
   logic [4:0] ro_a [4] = '{5'h06, 5'h08, 5'h0f, 5'h1f};
   logic [15:0] ro_e [4] = '{16'h0004, 16'h0000, 16'h8000, 16'h0000};
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   always #12.5 ref_clk = ~ref_clk;
   autoneg_next_page_regs i_autoneg_next_page_regs (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .page_valid(page_valid), .page_is_base(page_is_base), .page_in(page_in),
      .page_sent(page_sent), .tx_page(tx_page));
   an_engine_model i_an_engine_model (.ref_clk(ref_clk), .page_valid(page_valid), .page_is_base(page_is_base),
      .page_in(page_in), .page_sent(page_sent));
   task end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // tests need about 60 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task wr(input logic [4:0] a, input logic [15:0] d);
      {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
      @(negedge ref_clk);
      reg_write = 1'b0;
      `CHK("rvalid", 1'b0, reg_rvalid)
      @(negedge ref_clk);
   endtask
   // gap cycle after each read keeps strobes from being reassigned in one step
   task rd(input logic [4:0] a, input logic [15:0] e);
      {reg_addr, reg_read} = {a, 1'b1};
      @(negedge ref_clk);
      reg_read = 1'b0;
      `CHK("rvalid", 1'b1, reg_rvalid)
      `CHK("rdata", e, reg_rdata)
      @(negedge ref_clk);
   endtask
   initial begin
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      rd(5'h07, 16'h2001);
      `CHK("tx_page", 15'h2001, tx_page)
      for (int i = 0; i < 4; i++) begin
         wr(ro_a[i], 16'hffff);
         rd(ro_a[i], ro_e[i]);
      end
      $display("test 1 done");
      wr(5'h07, 16'hffff);
      rd(5'h07, 16'hb7ff);
      `CHK("tx_page", 15'h77ff, tx_page)
      i_an_engine_model.sent();
      rd(5'h07, 16'hbfff);
      i_an_engine_model.sent();
      rd(5'h07, 16'hb7ff);
      $display("test 2 done");
      i_an_engine_model.rx(15'h0000, 1'b1);
      rd(5'h06, 16'h0006);
      rd(5'h06, 16'h0004);
      rd(5'h08, 16'h4000);
      i_an_engine_model.rx(15'h6123, 1'b0);
      rd(5'h08, 16'he123);
      rd(5'h06, 16'h0006);
      i_an_engine_model.rx(15'h1055, 1'b0);
      rd(5'h08, 16'h5855);
      fork
         i_an_engine_model.rx(15'h0000, 1'b1);
         rd(5'h06, 16'h0006);
      join
      rd(5'h06, 16'h0006);
      $display("test 3 done");
      end_sim();
   end
endmodule
`default_nettype wire
